// file: hdl/cifc_cfg.svh
// register map, field positions and reset values of the interrupt flag controller
`ifndef CIFC_CFG_SVH
`define CIFC_CFG_SVH
`define CIFC_NUM_SRC 8
`define CIFC_ADDR_W 8
`define CIFC_DATA_W 32
`define CIFC_OFS_RAW 8'h00
`define CIFC_OFS_CLEAR 8'h04
`define CIFC_OFS_ENABLE 8'h08
`define CIFC_OFS_FAST_SEL 8'h0c
`define CIFC_OFS_CTRL 8'h10
`define CIFC_OFS_SPACING 8'h14
`define CIFC_OFS_PENDING 8'h18
`define CIFC_OFS_VECTOR 8'h1c
`define CIFC_SPACING_W 8
`define CIFC_SPACING_RESET 8'h01
`define CIFC_SPACING_INTENDED 8'h04
`define CIFC_CTRL_W 2
`define CIFC_CTRL_RESET 2'h0
`define CIFC_CTRL_FAST_BIT 0
`define CIFC_CTRL_NORM_BIT 1
`define CIFC_VEC_ADDR_W 16
`define CIFC_VEC_VALID_BIT 31
`endif

// file: hdl/cifc_pkg.sv
// types shared by the interrupt flag controller files
package cifc_pkg;
  typedef enum logic [3:0] {
    CIFC_REG_NONE = 4'h0,
    CIFC_REG_RAW = 4'h1,
    CIFC_REG_CLEAR = 4'h2,
    CIFC_REG_ENABLE = 4'h3,
    CIFC_REG_FAST_SEL = 4'h4,
    CIFC_REG_CTRL = 4'h5,
    CIFC_REG_SPACING = 4'h6,
    CIFC_REG_PENDING = 4'h7,
    CIFC_REG_VECTOR = 4'h8
  } cifc_reg_type;
endpackage

// file: hdl/cifc_flag_cell.sv
// one sticky status flag fed by one system interrupt input
module cifc_flag_cell (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source and software clear
  input wire logic irq_in,
  input wire logic clear,
  // sticky flag
  output logic flag
);
  logic next_flag;

  // every cycle the input is high counts as one pulse, so a held level keeps setting
  // no pulse count is kept, only the flag; set wins over a clear in the same cycle
  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (irq_in) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule

// file: hdl/cifc_top.sv
// interrupt flag controller: sticky flags, two request lines, vector spacing, apb slave
//
// What this block does
// - spacing resets to one byte, not four
// - route flags onto fast and normal requests
// - every input is taken as pulse train
// - one sticky flag per source, no count
// - clear during held level sets flag again
//
// The APB register port and the address map are this design's own decisions.
`include "cifc_cfg.svh"

module cifc_top
  import cifc_pkg::*;
#(
  parameter int NUM_SRC = `CIFC_NUM_SRC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [`CIFC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CIFC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`CIFC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // system interrupt inputs
  input wire logic [NUM_SRC-1:0] sys_irq,
  // processor request lines
  output logic fast_request,
  output logic normal_request,
  // vector of the lowest pending normal source
  output logic vector_valid,
  output logic [`CIFC_VEC_ADDR_W-1:0] vector_addr
);
  localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
  localparam int VW = `CIFC_VEC_ADDR_W;
  localparam int SW = `CIFC_SPACING_W;

  generate
    if (NUM_SRC < 1 || NUM_SRC > 32) begin : g_bad_num_src
      $error("NUM_SRC must be between 1 and 32");
    end
  endgenerate

  // offsets are byte addresses; a misaligned address maps to nothing
  function automatic cifc_reg_type decode(input logic [`CIFC_ADDR_W-1:0] a);
    case (a)
      `CIFC_OFS_RAW: decode = CIFC_REG_RAW;
      `CIFC_OFS_CLEAR: decode = CIFC_REG_CLEAR;
      `CIFC_OFS_ENABLE: decode = CIFC_REG_ENABLE;
      `CIFC_OFS_FAST_SEL: decode = CIFC_REG_FAST_SEL;
      `CIFC_OFS_CTRL: decode = CIFC_REG_CTRL;
      `CIFC_OFS_SPACING: decode = CIFC_REG_SPACING;
      `CIFC_OFS_PENDING: decode = CIFC_REG_PENDING;
      `CIFC_OFS_VECTOR: decode = CIFC_REG_VECTOR;
      default: decode = CIFC_REG_NONE;
    endcase
  endfunction

  function automatic logic [`CIFC_DATA_W-1:0] lane_mask(input logic [3:0] s);
    logic [`CIFC_DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  // register state
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] next_enable;
  logic [NUM_SRC-1:0] fast_sel;
  logic [NUM_SRC-1:0] next_fast_sel;
  logic [`CIFC_CTRL_W-1:0] ctrl;
  logic [`CIFC_CTRL_W-1:0] next_ctrl;
  logic [SW-1:0] vector_spacing_reg;
  logic [SW-1:0] next_vector_spacing_reg;
  logic spacing_written;
  logic next_spacing_written;
  logic [`CIFC_DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic next_fast_request;
  logic next_normal_request;
  logic next_vector_valid;
  logic [VW-1:0] next_vector_addr;

  // bus decode
  logic setup;
  logic wr;
  cifc_reg_type sel;
  logic [`CIFC_DATA_W-1:0] wmask;
  logic [NUM_SRC-1:0] wbits;
  logic [NUM_SRC-1:0] clr_vec;

  // routing
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] fast_pend;
  logic [NUM_SRC-1:0] norm_pend;
  logic [IDX_W-1:0] cur_idx;
  logic cur_valid;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign sel = decode(paddr);
  assign wmask = lane_mask(pstrb);
  assign wbits = pwdata[NUM_SRC-1:0] & wmask[NUM_SRC-1:0];
  // zero wait states: every access phase completes at its first edge
  assign pready = 1'b1;

  // write-one-to-clear; clearing while a held level is still high will not stick
  assign clr_vec = (wr && sel == CIFC_REG_CLEAR) ? wbits : '0;

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      cifc_flag_cell u_cifc_flag_cell (
        .pclk(pclk),
        .presetn(presetn),
        .irq_in(sys_irq[i]),
        .clear(clr_vec[i]),
        .flag(flags[i])
      );
    end
  endgenerate

  // software-written registers
  always_comb begin
    next_enable = enable;
    next_fast_sel = fast_sel;
    next_ctrl = ctrl;
    next_vector_spacing_reg = vector_spacing_reg;
    next_spacing_written = spacing_written;
    if (wr) begin
      case (sel)
        CIFC_REG_ENABLE: begin
          next_enable = (enable & ~wmask[NUM_SRC-1:0]) | wbits;
        end
        CIFC_REG_FAST_SEL: begin
          next_fast_sel = (fast_sel & ~wmask[NUM_SRC-1:0]) | wbits;
        end
        CIFC_REG_CTRL: begin
          if (pstrb[0]) begin
            next_ctrl = pwdata[`CIFC_CTRL_W-1:0];
          end
        end
        CIFC_REG_SPACING: begin
          // only an explicit write brings the spacing to its working value
          if (pstrb[0]) begin
            next_vector_spacing_reg = pwdata[SW-1:0];
            next_spacing_written = 1'b1;
          end
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  // read data latched in the setup phase so it is stable for the access phase
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_prdata = '0;
      next_pslverr = (sel == CIFC_REG_NONE);
      case (sel)
        CIFC_REG_RAW: next_prdata[NUM_SRC-1:0] = flags;
        CIFC_REG_CLEAR: next_prdata[NUM_SRC-1:0] = flags;
        CIFC_REG_ENABLE: next_prdata[NUM_SRC-1:0] = enable;
        CIFC_REG_FAST_SEL: next_prdata[NUM_SRC-1:0] = fast_sel;
        CIFC_REG_CTRL: next_prdata[`CIFC_CTRL_W-1:0] = ctrl;
        CIFC_REG_SPACING: next_prdata[SW-1:0] = vector_spacing_reg;
        CIFC_REG_PENDING: next_prdata[NUM_SRC-1:0] = pend;
        CIFC_REG_VECTOR: begin
          next_prdata[`CIFC_VEC_VALID_BIT] = vector_valid;
          next_prdata[VW-1:0] = vector_addr;
        end
        default: next_prdata = '0;
      endcase
    end
  end

  // combine flags onto exactly two request lines
  always_comb begin
    pend = flags & enable;
    fast_pend = pend & fast_sel;
    norm_pend = pend & ~fast_sel;
    next_fast_request = ctrl[`CIFC_CTRL_FAST_BIT] && (|fast_pend);
    next_normal_request = ctrl[`CIFC_CTRL_NORM_BIT] && (|norm_pend);
  end

  // lowest pending normal source wins; no priority levels are provided
  always_comb begin
    cur_idx = '0;
    cur_valid = |norm_pend;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (norm_pend[i]) begin
        cur_idx = IDX_W'(i);
      end
    end
    next_vector_valid = cur_valid;
    // stays one byte per entry until software writes the spacing
    next_vector_addr = VW'(cur_idx) * VW'(vector_spacing_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= '0;
      fast_sel <= '0;
      ctrl <= `CIFC_CTRL_RESET;
      vector_spacing_reg <= `CIFC_SPACING_RESET;
      spacing_written <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      fast_request <= 1'b0;
      normal_request <= 1'b0;
      vector_valid <= 1'b0;
      vector_addr <= '0;
    end else begin
      enable <= next_enable;
      fast_sel <= next_fast_sel;
      ctrl <= next_ctrl;
      vector_spacing_reg <= next_vector_spacing_reg;
      spacing_written <= next_spacing_written;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      fast_request <= next_fast_request;
      normal_request <= next_normal_request;
      vector_valid <= next_vector_valid;
      vector_addr <= next_vector_addr;
    end
  end

  // checks
  logic [NUM_SRC-1:0] hold_clr;
  logic [NUM_SRC-1:0] real_clr;
  logic [SW-1:0] wdata_lo;
  logic spacing_wr;
  assign hold_clr = clr_vec & sys_irq;
  assign real_clr = clr_vec & ~sys_irq;
  assign wdata_lo = pwdata[SW-1:0];
  assign spacing_wr = wr && (sel == CIFC_REG_SPACING) && pstrb[0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_spacing_reset;
    !spacing_written |-> vector_spacing_reg == `CIFC_SPACING_RESET;
  endproperty
  a_spacing_reset: assert property (p_spacing_reset)
    else $error("spacing not one byte before first write");

  property p_spacing_write;
    spacing_wr |=> vector_spacing_reg == $past(wdata_lo) && spacing_written;
  endproperty
  a_spacing_write: assert property (p_spacing_write)
    else $error("spacing write did not take effect");

  property p_fast_route;
    (fast_pend == '0 || !ctrl[`CIFC_CTRL_FAST_BIT]) |=> !fast_request;
  endproperty
  a_fast_route: assert property (p_fast_route)
    else $error("fast request without a fast pending source");

  property p_norm_route;
    (norm_pend != '0 && ctrl[`CIFC_CTRL_NORM_BIT]) |=> normal_request ##0 vector_valid;
  endproperty
  a_norm_route: assert property (p_norm_route)
    else $error("normal request missing for pending source");

  property p_level_train;
    1'b1 |=> (($past(sys_irq) & ~flags) == '0);
  endproperty
  a_level_train: assert property (p_level_train)
    else $error("high input cycle did not set its flag");

  property p_sticky;
    1'b1 |=> (($past(flags) & ~$past(clr_vec) & ~flags) == '0);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");

  property p_clear;
    (real_clr != '0) |=> ((flags & $past(real_clr)) == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared by software");

  property p_reflag;
    (hold_clr != '0) |=> ((flags & $past(hold_clr)) == $past(hold_clr));
  endproperty
  a_reflag: assert property (p_reflag)
    else $error("held level cleared without setting again");

  property p_vector;
    vector_valid |-> vector_addr == VW'($past(cur_idx)) * VW'($past(vector_spacing_reg));
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector address is not index times spacing");
endmodule

// file: verif/cifc_sig_source.sv
// level chip-signal source model whose status bit is cleared at its origin
module cifc_sig_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // handler controls
  input wire logic raise,
  input wire logic clear,
  // level request and status bit
  output logic level_irq,
  output logic status
);
  timeunit 1ns;
  timeprecision 100ps;
  logic next_status;
  always_comb begin
    next_status = status;
    if (clear) begin
      next_status = 1'b0;
    end else if (raise) begin
      next_status = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 1'b0;
    end else begin
      status <= next_status;
    end
  end
  // a level source: stays high until cleared here, not in the controller
  assign level_irq = status;
endmodule

// file: verif/cpu_interrupt_flag_controller_tb_top.sv
// self-checking bench of the interrupt flag controller
`include "cifc_cfg.svh"
module cpu_interrupt_flag_controller_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] tb_irq = 8'h00;
  logic [7:0] sys_irq;
  logic fast_request;
  logic normal_request;
  logic vector_valid;
  logic [15:0] vector_addr;
  logic src_raise = 1'b0;
  logic src_clear = 1'b0;
  logic src_irq;
  logic src_status;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_compared = 0;

  always #12.5 pclk = ~pclk;
  assign sys_irq = {tb_irq[7:4], src_irq, tb_irq[2:0]};

  cifc_top #(.NUM_SRC(8)) u_cifc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_irq(sys_irq),
    .fast_request(fast_request), .normal_request(normal_request),
    .vector_valid(vector_valid), .vector_addr(vector_addr));
  cifc_sig_source u_cifc_sig_source (.pclk(pclk), .presetn(presetn), .raise(src_raise),
    .clear(src_clear), .level_irq(src_irq), .status(src_status));

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // one apb transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      $display("FAIL pready expected 1 seen %b", pready);
      n_mismatch++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    tb_irq[b] <= 1'b1;
    @(posedge pclk);
    tb_irq[b] <= 1'b0;
  endtask

  // requests follow the flag one edge later; three leaves margin
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("spacing", `CIFC_OFS_SPACING, 32'h00000001);
    rchk("ctrl", `CIFC_OFS_CTRL, 32'h0);
    rchk("raw", `CIFC_OFS_RAW, 32'h0);
    $display("test reset done");
    apb(1'b1, `CIFC_OFS_ENABLE, 32'h000000ff);
    apb(1'b1, `CIFC_OFS_CTRL, 32'h00000003);
    apb(1'b1, `CIFC_OFS_FAST_SEL, 32'h00000001);
    pulse(2);
    settle();
    chk("vector_addr", 32'h2, {16'h0, vector_addr});
    chk("normal_request", 32'h1, {31'h0, normal_request});
    apb(1'b1, `CIFC_OFS_SPACING, 32'h00000004);
    settle();
    chk("vector_addr", 32'h8, {16'h0, vector_addr});
    pulse(0);
    settle();
    chk("fast_request", 32'h1, {31'h0, fast_request});
    chk("vector_addr", 32'h8, {16'h0, vector_addr});
    pulse(5);
    pulse(2);
    rchk("raw", `CIFC_OFS_RAW, 32'h00000025);
    apb(1'b1, `CIFC_OFS_CLEAR, 32'h00000004);
    rchk("raw", `CIFC_OFS_RAW, 32'h00000021);
    rchk("vector", `CIFC_OFS_VECTOR, 32'h80000014);
    apb(1'b1, `CIFC_OFS_CLEAR, 32'h00000021);
    settle();
    rchk("raw", `CIFC_OFS_RAW, 32'h0);
    chk("requests", 32'h0, {30'h0, fast_request, normal_request});
    $display("test routing done");
    @(posedge pclk);
    src_raise <= 1'b1;
    @(posedge pclk);
    src_raise <= 1'b0;
    settle();
    apb(1'b1, `CIFC_OFS_CLEAR, 32'h00000008);
    rchk("raw", `CIFC_OFS_RAW, 32'h00000008);
    chk("source status", 32'h1, {31'h0, src_status});
    chk("vector_addr", 32'hc, {16'h0, vector_addr});
    @(posedge pclk);
    src_clear <= 1'b1;
    @(posedge pclk);
    src_clear <= 1'b0;
    apb(1'b1, `CIFC_OFS_CLEAR, 32'h00000008);
    settle();
    rchk("raw", `CIFC_OFS_RAW, 32'h0);
    chk("normal_request", 32'h0, {31'h0, normal_request});
    $display("test level source done");
    pulse(1);
    apb(1'b1, `CIFC_OFS_CTRL, 32'h00000001);
    settle();
    chk("normal_request", 32'h0, {31'h0, normal_request});
    rchk("pending", `CIFC_OFS_PENDING, 32'h00000002);
    // spacing needs lane 0; a write without it must leave the value alone
    pstrb <= 4'he;
    apb(1'b1, `CIFC_OFS_SPACING, 32'h00000010);
    pstrb <= 4'hf;
    rchk("spacing", `CIFC_OFS_SPACING, 32'h00000004);
    rchk("vector", `CIFC_OFS_VECTOR, 32'h80000004);
    apb(1'b1, `CIFC_OFS_CLEAR, 32'h00000002);
    apb(1'b1, `CIFC_OFS_CTRL, 32'h00000003);
    $display("test strobes and line enable done");
    pulse(0);
    settle();
    chk("fast_request", 32'h1, {31'h0, fast_request});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("requests", 32'h0, {30'h0, fast_request, normal_request});
    presetn <= 1'b1;
    rchk("spacing", `CIFC_OFS_SPACING, 32'h00000001);
    rchk("raw", `CIFC_OFS_RAW, 32'h0);
    $display("test second reset done");
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("prdata", 32'h0, rd);
    $display("test unmapped done");
    test_done();
  end
endmodule
